// *** nsc_regs.svh ***
/*
 * Register map constants of the node switch configuration bank: offsets,
 * field positions, writable masks and reset values.
 * Assumes it is included by bare name from design files of this bank.
 */
`ifndef NSC_REGS_SVH
`define NSC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (configuration register numbers).
// ----------------------------------------------------------------------
`define NSC_OFF_IDENT     8'h00
`define NSC_OFF_TOPO      8'h01
`define NSC_OFF_SWCFG     8'h04
`define NSC_OFF_NODEID    8'h05
`define NSC_OFF_PLL       8'h06
`define NSC_OFF_SWDIV     8'h07

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define NSC_SWCFG_LOCK_BIT  31
`define NSC_SWCFG_PLLLK_BIT 8
`define NSC_SWCFG_HDR_BIT   0
`define NSC_PLL_ODIV_HI     25
`define NSC_PLL_ODIV_LO     23
`define NSC_PLL_F_HI        20
`define NSC_PLL_F_LO        8
`define NSC_PLL_R_HI        6
`define NSC_PLL_R_LO        0
`define NSC_STRAP_PAD       6'h00

// ----------------------------------------------------------------------
// Readable and writable masks; reserved bits read as zero.
// ----------------------------------------------------------------------
`define NSC_MASK_ALL      32'hffffffff
`define NSC_MASK_TOPO     32'h00ffffff
`define NSC_MASK_SWCFG    32'h80000101
`define NSC_MASK_LOW16    32'h0000ffff
`define NSC_MASK_PLL      32'h039fff7f
`define NSC_MASK_NONE     32'h00000000

// ----------------------------------------------------------------------
// Reset values; PLL word depends on the two boot strap pins.
// ----------------------------------------------------------------------
`define NSC_RST_ZERO      32'h00000000
`define NSC_PLL_RST_M0    32'h00800f00
`define NSC_PLL_RST_M1    32'h00801f01
`define NSC_PLL_RST_M2    32'h00002701
`define NSC_PLL_RST_M3    32'h01003b02
`define NSC_DIV_ZERO      16'h0000
`define NSC_DIV_ONE       16'h0001

`endif

// *** nsc_pkg.sv ***
/*
 * Types shared by the node switch configuration bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package nsc_pkg;

	// Start-up sequence states, one-hot.
	typedef enum logic [3:0] {
		NSC_ST_SETTLE0 = 4'h1,
		NSC_ST_SETTLE1 = 4'h2,
		NSC_ST_CAPTURE = 4'h4,
		NSC_ST_RUN     = 4'h8
	} nsc_state_e;

endpackage : nsc_pkg

`default_nettype wire

// *** nsc_route_cmp.sv ***
/*
 * Routing comparator: matches an incoming destination against this node's
 * identifier, most significant bit first, and reports the first mismatch.
 * Assumes destinations arrive on the same clock as the configuration bank.
 */
`default_nettype none

module nsc_route_cmp
	import nsc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [15:0] node_id,
	input  wire logic        msg_valid,
	input  wire logic [15:0] msg_dest,
	output var  logic        route_valid_q,
	output var  logic        route_local_q,
	output var  logic [3:0]  route_bit_q
);

	// ------------------------------------------------------------------
	// Mismatch search.
	// ------------------------------------------------------------------

	// Returns the index of the highest differing bit, scanning downward.
	function automatic logic [3:0] first_mismatch(input logic [15:0] diff);
		logic [3:0] idx;
		logic       found;
		idx   = 4'h0;
		found = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			if (diff[i] && !found) begin
				idx   = 4'(i);
				found = 1'b1;
			end
		end
		return idx;
	endfunction

	// Registers the comparison result one cycle after the message.
	always_ff @(posedge clock) begin
		if (srst) begin
			route_valid_q <= 1'b0;
			route_local_q <= 1'b0;
			route_bit_q   <= 4'h0;
		end else begin
			route_valid_q <= msg_valid;
			route_local_q <= (msg_dest == node_id);
			route_bit_q   <= first_mismatch(msg_dest ^ node_id);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_route_msb_first: assert property (msg_valid && msg_dest[15] != node_id[15]
		|=> route_bit_q == 4'hf && !route_local_q)
		else $error("route mismatch not reported at top bit");
	a_route_local: assert property (msg_valid && msg_dest == node_id
		|=> route_valid_q && route_local_q)
		else $error("matching destination not reported local");

endmodule : nsc_route_cmp

`default_nettype wire

// *** nsc_cfg_regs.sv ***
/*
 * Configuration register bank of the node interconnect switch.
 * Holds identity, sampled boot straps, topology, lock and header bits,
 * the node identifier, PLL ratios and the switch clock divider.
 * Assumes one clock (the PLL clock), a synchronous active-high reset and
 * a host that issues configuration reads and writes on the cfg port.
 */
`default_nettype none
`include "nsc_regs.svh"

module nsc_cfg_regs
	import nsc_pkg::*;
#(
	parameter logic [7:0] CHIP_ID      = 8'h5a, // Arbitrary value.
	parameter logic [7:0] SW_REVISION  = 8'h01, // Arbitrary value.
	parameter logic [7:0] SW_VERSION   = 8'h02, // Arbitrary value.
	parameter logic [7:0] LINK_COUNT   = 8'h08,
	parameter logic [7:0] CORE_COUNT   = 8'h01,
	parameter logic [7:0] LINKS_PER_PE = 8'h04
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        boot_strap_pin_0,
	input  wire logic        boot_strap_pin_1,
	input  wire logic        cfg_req,
	input  wire logic        cfg_write,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [31:0] cfg_wdata,
	output var  logic        cfg_ack_q,
	output var  logic        cfg_err_q,
	output var  logic [31:0] cfg_rdata_q,
	input  wire logic        msg_valid,
	input  wire logic [15:0] msg_dest,
	output var  logic        route_valid_q,
	output var  logic        route_local_q,
	output var  logic [3:0]  route_bit_q,
	output var  logic        header_one_byte_q,
	output var  logic [2:0]  pll_output_divider_q,
	output var  logic [12:0] pll_feedback_ratio_q,
	output var  logic [6:0]  pll_input_divider_q,
	output var  logic        tile_reset_q,
	output var  logic        switch_clk_en_q
);
	// ------------------------------------------------------------------
	// Register decode helpers.
	// ------------------------------------------------------------------
	// Bits that read back for each offset; zero mask means unmapped.
	function automatic logic [31:0] rd_mask(input logic [7:0] a);
		case (a)
			`NSC_OFF_IDENT:  rd_mask = `NSC_MASK_ALL;
			`NSC_OFF_TOPO:   rd_mask = `NSC_MASK_TOPO;
			`NSC_OFF_SWCFG:  rd_mask = `NSC_MASK_SWCFG;
			`NSC_OFF_NODEID: rd_mask = `NSC_MASK_LOW16;
			`NSC_OFF_PLL:    rd_mask = `NSC_MASK_PLL;
			`NSC_OFF_SWDIV:  rd_mask = `NSC_MASK_LOW16;
			default:         rd_mask = `NSC_MASK_NONE;
		endcase
	endfunction

	// Bits that software may change for each offset.
	function automatic logic [31:0] wr_mask(input logic [7:0] a);
		case (a)
			`NSC_OFF_SWCFG:  wr_mask = `NSC_MASK_SWCFG;
			`NSC_OFF_NODEID: wr_mask = `NSC_MASK_LOW16;
			`NSC_OFF_PLL:    wr_mask = `NSC_MASK_PLL;
			`NSC_OFF_SWDIV:  wr_mask = `NSC_MASK_LOW16;
			default:         wr_mask = `NSC_MASK_NONE;
		endcase
	endfunction

	// Strap-dependent PLL reset word.
	function automatic logic [31:0] pll_reset_word(input logic [1:0] s);
		case (s)
			2'h0:    pll_reset_word = `NSC_PLL_RST_M0;
			2'h1:    pll_reset_word = `NSC_PLL_RST_M1;
			2'h2:    pll_reset_word = `NSC_PLL_RST_M2;
			default: pll_reset_word = `NSC_PLL_RST_M3;
		endcase
	endfunction
	// ------------------------------------------------------------------
	// State and storage.
	// ------------------------------------------------------------------
	nsc_state_e  state_q;     // Start-up sequence state.
	logic [1:0]  strap_s1_q;  // First synchroniser stage of the straps.
	logic [1:0]  strap_s2_q;  // Second synchroniser stage of the straps.
	logic [1:0]  strap_q;     // Straps as captured after reset.
	logic [31:0] swcfg_q;     // Lock and header configuration.
	logic [15:0] node_id_q;   // Routing identifier of this node.
	logic [31:0] pll_q;       // PLL ratio settings word.
	logic [15:0] div_q;       // Switch clock divider.
	logic [15:0] div_cnt_q;   // Divider phase counter.
	logic [31:0] rd_word;     // Unmasked read value.
	logic        running;     // Bank has left start-up.
	logic        is_wr;       // A write request this cycle.
	logic        refused;     // Write blocked by a lock or target.
	logic        wr_ok;       // Write that updates storage.
	logic [7:0]  addr_q;      // Address of the answered access.

	assign running = (state_q == NSC_ST_RUN);
	assign is_wr   = cfg_req && cfg_write;

	// A write is refused while locked, while still starting, or on a
	// read-only or unmapped target.
	assign refused = !running || wr_mask(cfg_addr) == `NSC_MASK_NONE
		|| swcfg_q[`NSC_SWCFG_LOCK_BIT]
		|| (cfg_addr == `NSC_OFF_PLL && swcfg_q[`NSC_SWCFG_PLLLK_BIT]);
	assign wr_ok   = is_wr && !refused;
	// ------------------------------------------------------------------
	// Strap synchroniser and start-up sequence.
	// ------------------------------------------------------------------
	// Two stages bring the strap pins into the clock domain.
	always_ff @(posedge clock) begin
		strap_s1_q <= {boot_strap_pin_1, boot_strap_pin_0};
		strap_s2_q <= strap_s1_q;
	end

	// Waits for the synchroniser to refill, captures straps, then runs.
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= NSC_ST_SETTLE0;
		end else begin
			case (state_q)
				NSC_ST_SETTLE0: state_q <= NSC_ST_SETTLE1;
				NSC_ST_SETTLE1: state_q <= NSC_ST_CAPTURE;
				NSC_ST_CAPTURE: state_q <= NSC_ST_RUN;
				NSC_ST_RUN:     state_q <= NSC_ST_RUN;
				default:        state_q <= NSC_ST_SETTLE0;
			endcase
		end
	end

	// Strap levels are held from capture until the next reset.
	always_ff @(posedge clock) begin
		if (srst) begin
			strap_q <= 2'h0;
		end else if (state_q == NSC_ST_CAPTURE) begin
			strap_q <= strap_s2_q;
		end
	end
	// ------------------------------------------------------------------
	// Writable registers.
	// ------------------------------------------------------------------
	// Switch configuration: lock bits and header mode.
	always_ff @(posedge clock) begin
		if (srst) begin
			swcfg_q <= `NSC_RST_ZERO;
		end else if (wr_ok && cfg_addr == `NSC_OFF_SWCFG) begin
			swcfg_q <= cfg_wdata & `NSC_MASK_SWCFG;
		end
	end

	// Node identifier, low sixteen bits only.
	always_ff @(posedge clock) begin
		if (srst) begin
			node_id_q <= `NSC_DIV_ZERO;
		end else if (wr_ok && cfg_addr == `NSC_OFF_NODEID) begin
			node_id_q <= cfg_wdata[15:0];
		end
	end

	// PLL ratios: strap-dependent load at capture, then host writes.
	always_ff @(posedge clock) begin
		if (srst) begin
			pll_q <= `NSC_RST_ZERO;
		end else if (state_q == NSC_ST_CAPTURE) begin
			pll_q <= pll_reset_word(strap_s2_q);
		end else if (wr_ok && cfg_addr == `NSC_OFF_PLL) begin
			pll_q <= cfg_wdata & `NSC_MASK_PLL;
		end
	end

	// Switch clock divider.
	always_ff @(posedge clock) begin
		if (srst) begin
			div_q <= `NSC_DIV_ZERO;
		end else if (wr_ok && cfg_addr == `NSC_OFF_SWDIV) begin
			div_q <= cfg_wdata[15:0];
		end
	end
	// ------------------------------------------------------------------
	// Outputs driven by the registers.
	// ------------------------------------------------------------------
	// Copies of the PLL and header fields for the clock and link logic.
	always_ff @(posedge clock) begin
		if (srst) begin
			header_one_byte_q    <= 1'b0;
			pll_output_divider_q <= 3'h0;
			pll_feedback_ratio_q <= 13'h0000;
			pll_input_divider_q  <= 7'h00;
		end else begin
			header_one_byte_q    <= swcfg_q[`NSC_SWCFG_HDR_BIT];
			pll_output_divider_q <= pll_q[`NSC_PLL_ODIV_HI:`NSC_PLL_ODIV_LO];
			pll_feedback_ratio_q <= pll_q[`NSC_PLL_F_HI:`NSC_PLL_F_LO];
			pll_input_divider_q  <= pll_q[`NSC_PLL_R_HI:`NSC_PLL_R_LO];
		end
	end

	// A PLL write that is taken pulses the tile reset for one cycle.
	always_ff @(posedge clock) begin
		if (srst) begin
			tile_reset_q <= 1'b0;
		end else begin
			tile_reset_q <= wr_ok && cfg_addr == `NSC_OFF_PLL;
		end
	end

	// Switch clock enable: one pulse every divider+1 PLL clock cycles.
	always_ff @(posedge clock) begin
		if (srst) begin
			div_cnt_q       <= `NSC_DIV_ZERO;
			switch_clk_en_q <= 1'b0;
		end else if (div_cnt_q >= div_q) begin
			div_cnt_q       <= `NSC_DIV_ZERO;
			switch_clk_en_q <= 1'b1;
		end else begin
			div_cnt_q       <= div_cnt_q + `NSC_DIV_ONE;
			switch_clk_en_q <= 1'b0;
		end
	end
	// ------------------------------------------------------------------
	// Configuration answer path.
	// ------------------------------------------------------------------
	// Raw read word before reserved bits are cleared.
	always_comb begin
		case (cfg_addr)
			`NSC_OFF_IDENT:  rd_word = {CHIP_ID, `NSC_STRAP_PAD, strap_q,
				SW_REVISION, SW_VERSION};
			`NSC_OFF_TOPO:   rd_word = {8'h00, LINK_COUNT, CORE_COUNT,
				LINKS_PER_PE};
			`NSC_OFF_SWCFG:  rd_word = swcfg_q;
			`NSC_OFF_NODEID: rd_word = {16'h0000, node_id_q};
			`NSC_OFF_PLL:    rd_word = pll_q;
			`NSC_OFF_SWDIV:  rd_word = {16'h0000, div_q};
			default:         rd_word = `NSC_RST_ZERO;
		endcase
	end

	// Every request is answered one cycle later; errors flag refusals.
	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_ack_q   <= 1'b0;
			cfg_err_q   <= 1'b0;
			cfg_rdata_q <= `NSC_RST_ZERO;
			addr_q      <= 8'h00;
		end else begin
			cfg_ack_q <= cfg_req;
			addr_q    <= cfg_addr;
			if (cfg_req && cfg_write) begin
				cfg_err_q   <= refused;
				cfg_rdata_q <= `NSC_RST_ZERO;
			end else if (cfg_req) begin
				cfg_err_q   <= !running || rd_mask(cfg_addr) == `NSC_MASK_NONE;
				cfg_rdata_q <= rd_word & rd_mask(cfg_addr);
			end else begin
				cfg_err_q   <= 1'b0;
				cfg_rdata_q <= `NSC_RST_ZERO;
			end
		end
	end

	// Routing comparator against the stored identifier.
	nsc_route_cmp u_route (
		.clock         (clock),
		.srst          (srst),
		.node_id       (node_id_q),
		.msg_valid     (msg_valid),
		.msg_dest      (msg_dest),
		.route_valid_q (route_valid_q),
		.route_local_q (route_local_q),
		.route_bit_q   (route_bit_q)
	);
	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	a_lock_refuse: assert property (swcfg_q[`NSC_SWCFG_LOCK_BIT] && is_wr
		|=> cfg_ack_q && cfg_err_q && $stable(node_id_q) && $stable(pll_q))
		else $error("write taken while globally locked");
	a_pll_blocked: assert property (running && is_wr && cfg_addr == `NSC_OFF_PLL
		&& swcfg_q[`NSC_SWCFG_PLLLK_BIT] |=> $stable(pll_q) && !tile_reset_q && cfg_err_q)
		else $error("PLL write taken while PLL locked");
	a_header_mode: assert property (wr_ok && cfg_addr == `NSC_OFF_SWCFG
		|-> ##2 header_one_byte_q == $past(cfg_wdata[0], 2))
		else $error("header mode does not follow write");
	a_node_id_wr: assert property (wr_ok && cfg_addr == `NSC_OFF_NODEID
		|=> node_id_q == $past(cfg_wdata[15:0]))
		else $error("node identifier not updated");
	a_tile_reset: assert property (tile_reset_q
		|-> $past(wr_ok) && $past(cfg_addr) == `NSC_OFF_PLL)
		else $error("tile reset without PLL write");
	a_pll_fields: assert property (wr_ok && cfg_addr == `NSC_OFF_PLL
		|-> ##2 pll_output_divider_q == $past(cfg_wdata[25:23], 2)
		&& pll_feedback_ratio_q == $past(cfg_wdata[20:8], 2)
		&& pll_input_divider_q == $past(cfg_wdata[6:0], 2))
		else $error("PLL fields do not follow write");
	a_pll_strap_reset: assert property (state_q == NSC_ST_CAPTURE
		|=> pll_q == pll_reset_word(strap_q))
		else $error("PLL reset word does not follow straps");
	a_ident_read: assert property (running && cfg_req && !cfg_write
		&& cfg_addr == `NSC_OFF_IDENT |=> cfg_rdata_q[31:24] == CHIP_ID
		&& cfg_rdata_q[17:16] == strap_q && cfg_rdata_q[7:0] == SW_VERSION)
		else $error("identity read wrong");
	a_topo_read: assert property (running && cfg_req && !cfg_write
		&& cfg_addr == `NSC_OFF_TOPO |=> cfg_rdata_q[23:16] == LINK_COUNT
		&& cfg_rdata_q[15:8] == CORE_COUNT && cfg_rdata_q[7:0] == LINKS_PER_PE)
		else $error("topology read wrong");
	a_div_zero: assert property ((div_q == 16'h0000) [*3] |-> switch_clk_en_q)
		else $error("undivided switch clock not continuous");
	a_reserved_zero: assert property (cfg_ack_q
		|-> (cfg_rdata_q & ~rd_mask(addr_q)) == 32'h00000000)
		else $error("reserved bits read nonzero");
	c_pll_write: cover property (wr_ok && cfg_addr == `NSC_OFF_PLL ##1 tile_reset_q);
	c_lock_refuse: cover property (swcfg_q[`NSC_SWCFG_LOCK_BIT] && is_wr ##1 cfg_err_q);
	c_route_local: cover property (route_valid_q && route_local_q);

endmodule : nsc_cfg_regs

`default_nettype wire

// *** nsc_host_model.sv ***
/*
 * Host model: issues configuration reads and writes to the bank.
 * Assumes the bank samples requests on rising edges; this model drives at
 * falling edges and reads the answer in the cycle that follows.
 */
`default_nettype none

module nsc_host_model (
	input  wire logic        clock,
	output var  logic        cfg_req,
	output var  logic        cfg_write,
	output var  logic [7:0]  cfg_addr,
	output var  logic [31:0] cfg_wdata,
	input  wire logic        cfg_ack_q,
	input  wire logic        cfg_err_q,
	input  wire logic [31:0] cfg_rdata_q
);
	timeunit 1ns;
	timeprecision 1ps;

	// The port is quiet from time zero.
	initial begin
		cfg_req = 1'b0;
		cfg_write = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 32'h00000000;
	end

	// One transfer: a one-cycle request, then the answer one cycle later.
	task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
		output logic ok, output logic [31:0] rd, output logic er);
		@(negedge clock);
		cfg_req = 1'b1;
		cfg_write = wr;
		cfg_addr = adr;
		cfg_wdata = wd;
		@(negedge clock);
		ok = cfg_ack_q;
		rd = cfg_rdata_q;
		er = cfg_err_q;
		// Released lines show the inverse so a stale value never looks live.
		cfg_req = 1'b0;
		cfg_write = ~wr;
		cfg_addr = ~adr;
		cfg_wdata = ~wd;
	endtask
endmodule // nsc_host_model

`default_nettype wire

// *** nsc_cfg_regs_tb.sv ***
/*
 * Self-checking testbench of the configuration bank.
 * Assumes the host model file is compiled first; straps start at {1,0}
 * and take other levels across resets in mid-run.
 */
`default_nettype none
`include "nsc_regs.svh"

module nsc_cfg_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock, srst, pin0, pin1, req, wr, ack, err, msg_valid;
	logic        rv, rl, hdr, trst, clk_en;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, rdv;
	logic [15:0] msg_dest;
	logic [3:0]  rbit;
	logic [2:0]  od;
	logic [12:0] fb;
	logic [6:0]  idv;
	int          miscompares, cmp_count, cyc;

	// ----------------------------------------------------------------------
	// Design, with an arbitrary chip code, and the host.
	// ----------------------------------------------------------------------
	nsc_cfg_regs #(.CHIP_ID(8'h3c)) i_dut (.clock(clock), .srst(srst),
		.boot_strap_pin_0(pin0), .boot_strap_pin_1(pin1), .cfg_req(req),
		.cfg_write(wr), .cfg_addr(addr), .cfg_wdata(wdata), .cfg_ack_q(ack),
		.cfg_err_q(err), .cfg_rdata_q(rdata), .msg_valid(msg_valid),
		.msg_dest(msg_dest), .route_valid_q(rv), .route_local_q(rl),
		.route_bit_q(rbit), .header_one_byte_q(hdr), .pll_output_divider_q(od),
		.pll_feedback_ratio_q(fb), .pll_input_divider_q(idv),
		.tile_reset_q(trst), .switch_clk_en_q(clk_en));
	nsc_host_model i_host (.clock(clock), .cfg_req(req), .cfg_write(wr),
		.cfg_addr(addr), .cfg_wdata(wdata), .cfg_ack_q(ack), .cfg_err_q(err),
		.cfg_rdata_q(rdata));

	// The clock toggles every 2 ns for 250 MHz.
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// A hang counts as a mismatch and ends the run.
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			final_report();
		end
	end

	// ----------------------------------------------------------------------
	// Shared checks and transfers.
	// ----------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A transfer whose acknowledge and refusal flag are both judged.
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic exp_err);
		logic ok, er;
		i_host.xfer(w, a, d, ok, rdv, er);
		chk({30'h0, ok, er}, {30'h0, 1'b1, exp_err});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0, 1'b0);
		chk(rdv, exp);
	endtask

	task automatic pll_out(input logic [22:0] exp);
		chk({9'h0, od, fb, idv}, {9'h0, exp});
	endtask

	// Counts switch clock enables over a number of cycles.
	task automatic pulses(input int n, input int exp);
		int c;
		c = 0;
		repeat (n) begin
			@(negedge clock);
			c += int'(clk_en);
		end
		chk(c, exp);
	endtask

	// One message: answer next cycle with the match and first mismatch bit.
	task automatic route(input logic [15:0] d, input logic loc, input logic [3:0] b);
		@(negedge clock);
		msg_valid = 1'b1;
		msg_dest = d;
		@(negedge clock);
		msg_valid = 1'b0;
		msg_dest = ~d;
		chk({26'h0, rv, rl, rbit}, {26'h0, 1'b1, loc, b});
	endtask

	// ----------------------------------------------------------------------
	// Scenarios.
	// ----------------------------------------------------------------------
	task automatic t_reset;
		rd_chk(8'h00, 32'h3c020102);
		rd_chk(8'h01, 32'h00080104);
		rd_chk(8'h04, 32'h00000000);
		rd_chk(8'h05, 32'h00000000);
		rd_chk(8'h06, 32'h00002701);
		pll_out({3'h0, 13'h0027, 7'h01});
		rd_chk(8'h07, 32'h00000000);
		pulses(8, 8);
		$display("test reset done");
	endtask

	task automatic t_route;
		acc(1'b1, 8'h05, 32'hffffabcd, 1'b0);
		rd_chk(8'h05, 32'h0000abcd);
		route(16'habcd, 1'b1, 4'h0);
		route(16'ha2cd, 1'b0, 4'hb);
		route(16'h2bcc, 1'b0, 4'hf);
		$display("test route done");
	endtask

	task automatic t_pll;
		acc(1'b1, 8'h06, 32'hffffffff, 1'b0);
		chk({31'h0, trst}, 32'h1);
		@(negedge clock);
		chk({31'h0, trst}, 32'h0);
		pll_out({3'h7, 13'h1fff, 7'h7f});
		rd_chk(8'h06, 32'h039fff7f);
		acc(1'b1, 8'h06, 32'h01000005, 1'b0);
		rd_chk(8'h06, 32'h01000005);
		$display("test pll done");
	endtask

	task automatic t_header;
		acc(1'b1, 8'h04, 32'h7fffffff, 1'b0);
		repeat (2) @(negedge clock);
		chk({31'h0, hdr}, 32'h1);
		rd_chk(8'h04, 32'h00000101);
		acc(1'b1, 8'h06, 32'h00000000, 1'b1);
		chk({31'h0, trst}, 32'h0);
		rd_chk(8'h06, 32'h01000005);
		$display("test header done");
	endtask

	task automatic t_div;
		acc(1'b1, 8'h07, 32'hffff0003, 1'b0);
		rd_chk(8'h07, 32'h00000003);
		pulses(8, 2);
		pulses(40, 10);
		$display("test divider done");
	endtask

	task automatic t_unmapped;
		acc(1'b0, 8'h02, 32'h0, 1'b1);
		chk(rdv, 32'h00000000);
		acc(1'b1, 8'h01, 32'hffffffff, 1'b1);
		rd_chk(8'h01, 32'h00080104);
		$display("test unmapped done");
	endtask

	task automatic t_lock;
		acc(1'b1, 8'h04, 32'h80000000, 1'b0);
		acc(1'b1, 8'h05, 32'h00001234, 1'b1);
		rd_chk(8'h05, 32'h0000abcd);
		acc(1'b1, 8'h04, 32'h00000000, 1'b1);
		rd_chk(8'h04, 32'h80000000);
		chk({31'h0, hdr}, 32'h0);
		$display("test lock done");
	endtask

	// Reset in mid-run with other strap levels: the identity and PLL word
	// must follow the new straps, and lock, identifier and divider clear.
	task automatic t_straps(input logic p1, input logic p0, input logic [31:0] pw);
		@(negedge clock);
		srst = 1'b1;
		pin1 = p1;
		pin0 = p0;
		repeat (3) @(negedge clock);
		srst = 1'b0;
		repeat (4) @(negedge clock);
		rd_chk(8'h00, {8'h3c, 6'h00, p1, p0, 16'h0102});
		rd_chk(8'h06, pw);
		pll_out({pw[25:23], pw[20:8], pw[6:0]});
		rd_chk(8'h04, 32'h00000000);
		rd_chk(8'h05, 32'h00000000);
		pulses(8, 8);
		$display("test straps %0d%0d done", p1, p0);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic final_report;
		$display("compares=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Reset for 16 cycles with straps {1,0}, then the scenarios in turn.
	initial begin
		srst = 1'b1;
		pin0 = 1'b0;
		pin1 = 1'b1;
		msg_valid = 1'b0;
		msg_dest = 16'h0000;
		repeat (16) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		repeat (4) @(negedge clock);
		t_reset();
		t_route();
		t_pll();
		t_header();
		t_div();
		t_unmapped();
		t_lock();
		t_straps(1'b0, 1'b0, `NSC_PLL_RST_M0);
		t_straps(1'b0, 1'b1, `NSC_PLL_RST_M1);
		t_straps(1'b1, 1'b1, `NSC_PLL_RST_M3);
		final_report();
	end
endmodule // nsc_cfg_regs_tb

`default_nettype wire
